// ### include/lacc_defs.svh
// register offsets, field positions, reset values and counts for the load-adaptive current block
`ifndef LACC_DEFS_SVH
`define LACC_DEFS_SVH

// byte offsets of the register words
`define LACC_OFS_LOAD_CFG    6'h00
`define LACC_OFS_SWITCH_MODE 6'h04
`define LACC_OFS_COOL_CFG    6'h08
`define LACC_OFS_CURRENT     6'h0C
`define LACC_OFS_LOW_VEL     6'h10
`define LACC_OFS_HIGH_VEL    6'h14
`define LACC_OFS_STATUS      6'h18
`define LACC_OFS_IRQ_STATUS  6'h1C
`define LACC_OFS_IRQ_MASK    6'h20

// load configuration word
`define LACC_FILT_EN_BIT     0
`define LACC_SENS_LSB        16
`define LACC_SENS_MSB        22
// switch mode word
`define LACC_STOP_STALL_BIT  0
// regulation configuration word
`define LACC_LOWER_LSB       0
`define LACC_SPAN_LSB        4
`define LACC_INC_LSB         8
`define LACC_DEC_LSB         10
`define LACC_MINSEL_BIT      12
// current word
`define LACC_RUN_LSB         0
`define LACC_HOLD_LSB        8
// status word
`define LACC_ST_LOAD_LSB     0
`define LACC_ST_SCALE_LSB    16
`define LACC_ST_ACTIVE_BIT   24
// interrupt bits
`define LACC_IRQ_STALL       0
`define LACC_IRQ_READING     1
`define LACC_IRQ_RAISED      2
`define LACC_IRQ_LOWERED     3
`define LACC_IRQ_W           4

// reset values
`define LACC_RST_RUN         5'h1F
`define LACC_RST_HOLD        5'h08
`define LACC_RST_SENS        7'h00

// threshold scale, ignored velocity bits, filter depth
`define LACC_THR_SHIFT       5
`define LACC_VEL_DROP        8
`define LACC_FILT_DEPTH      4

`endif

// ### include/lacc_pkg.sv
// types shared by the load-adaptive current block
package lacc_pkg;
  typedef logic [9:0]        lacc_load_t;   // 10-bit load reading
  typedef logic [4:0]        lacc_scale_t;  // current scale 0..31 = 1/32..32/32
  typedef logic signed [6:0] lacc_sens_t;   // signed stall sensitivity
  typedef enum logic [1:0] {ADJ_KEEP, ADJ_UP, ADJ_COUNT, ADJ_RESET} lacc_adj_e;
endpackage : lacc_pkg

// ### src/lacc_load_filter.sv
// four-reading load filter with raw pass-through
`timescale 1ns/1ps
`include "lacc_defs.svh"

module lacc_load_filter (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // control
  input  wire logic              filter_en,
  // raw reading, one per full step
  input  wire logic              in_valid,
  input  wire lacc_pkg::lacc_load_t in_load,
  // delivered reading
  output logic                   out_valid,
  output lacc_pkg::lacc_load_t   out_load
);
  import lacc_pkg::*;

  logic [11:0] sum_reg;
  logic [1:0]  cnt_reg;
  logic [11:0] sum_next;

  assign sum_next = sum_reg + {2'h0, in_load};

  // -----------------------------------------------------------------
  // averaging
  // -----------------------------------------------------------------
  // disabling drops a partial group so a later enable starts aligned
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_reg   <= 12'h000;
      cnt_reg   <= 2'h0;
      out_valid <= 1'b0;
      out_load  <= 10'h000;
    end else begin
      out_valid <= 1'b0;
      if (!filter_en) begin
        sum_reg <= 12'h000;
        cnt_reg <= 2'h0;
        if (in_valid) begin
          out_valid <= 1'b1;     // one result per full step [RL1]
          out_load  <= in_load;
        end
      end else if (in_valid) begin
        if (cnt_reg == 2'(`LACC_FILT_DEPTH - 1)) begin
          out_valid <= 1'b1;     // one result per four full steps [RL2] [RL3]
          out_load  <= sum_next[11:2];
          sum_reg   <= 12'h000;
          cnt_reg   <= 2'h0;
        end else begin
          sum_reg <= sum_next;
          cnt_reg <= cnt_reg + 2'h1;
        end
      end
    end
  end
endmodule : lacc_load_filter

// ### src/lacc_top.sv
// load-adaptive coil current regulation with stall stop and avalon-mm registers
// Function
// (RL1) new load reading every full step
// (RL2) filter enable averages four successive readings
// (RL3) filtered mode delivers one result per four steps
// (RL4) zero reading stops ramp when stop enabled
// (RL5) lower threshold is field times 32; zero disables
// (RL6) reading below lower threshold raises current
// (RL7) upper threshold (lower+span+1)*32, enough readings lower current
// (RL8) increment step codes give 1,2,4,8
// (RL9) decrement needs 32,8,2,1 readings per step
// (RL10) restart high-reading count after decrement or dip
// (RL11) minimum select: half or quarter of run
// (RL12) scale stays between minimum and run current; the code caps a raise at run only and does not lift it to minimum
// (RL13) below low velocity: regulation off, normal current
// (RL14) above high velocity: regulation off
// (RL15) velocity compares ignore low eight bits
// (RL16) actual scale readable, 0..31
// (RL17) signed stall sensitivity, zero neutral
// (RL18) software disables stall detection outside tuned range
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "lacc_defs.svh"

module lacc_top #(
  parameter int VEL_W = 23
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // avalon-mm slave
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // load measurement
  input  wire logic                 full_step,
  input  wire lacc_pkg::lacc_load_t meas_load,
  output lacc_pkg::lacc_sens_t      stall_sensitivity,
  // ramp generator
  input  wire logic [VEL_W-1:0]     actual_velocity,
  input  wire logic                 standstill,
  output logic                      ramp_stop,
  // coil drive
  output lacc_pkg::lacc_scale_t     actual_current_scale,
  // interrupt
  output logic                      irq
);
  import lacc_pkg::*;

  // --------------------
  // helpers
  // --------------------
  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] lacc_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) res[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return res;
  endfunction : lacc_merge

  // keep a scale inside [lo, hi]
  function automatic lacc_scale_t lacc_clamp(input lacc_scale_t v,
                                             input lacc_scale_t lo,
                                             input lacc_scale_t hi);
    lacc_scale_t res;
    res = v;
    if (res > hi) res = hi;
    if (res < lo) res = lo;
    return res;
  endfunction : lacc_clamp

  // upper bits of a velocity used by the window compare
  function automatic logic [VEL_W-`LACC_VEL_DROP-1:0] lacc_vel_hi(input logic [VEL_W-1:0] v);
    return v[VEL_W-1:`LACC_VEL_DROP];  // low eight bits ignored [RL15]
  endfunction : lacc_vel_hi

  // --------------------
  // registers
  // --------------------
  logic                 filt_en_reg;
  lacc_sens_t           sens_reg;
  logic                 stop_en_reg;
  logic [3:0]           lower_reg;
  logic [3:0]           span_reg;
  logic [1:0]           inc_reg;
  logic [1:0]           dec_reg;
  logic                 minsel_reg;
  lacc_scale_t          run_reg;
  lacc_scale_t          hold_reg;
  logic [VEL_W-1:0]     low_vel_reg;
  logic [VEL_W-1:0]     high_vel_reg;
  logic [`LACC_IRQ_W-1:0] irq_status_reg;
  logic [`LACC_IRQ_W-1:0] irq_mask_reg;
  logic [`LACC_IRQ_W-1:0] irq_set;
  logic [`LACC_IRQ_W-1:0] irq_clr;
  logic [31:0]          readdata_reg;
  logic                 waitrequest_reg;
  logic                 irq_reg;
  logic                 stop_reg;
  lacc_scale_t          scale_reg;
  lacc_scale_t          scale_next;
  logic [4:0]           hi_cnt_reg;
  logic                 active_reg;
  lacc_load_t           load_status_reg;

  logic                 bus_req;
  logic                 wr_acc;
  logic [31:0]          cur_word;
  logic [31:0]          wr_word;

  // --------------------
  // avalon-mm handshake
  // --------------------
  // one wait state: waitrequest drops for one cycle per request, so the
  // read word is latched the cycle before the master samples it
  assign bus_req = avs_read | avs_write;
  assign wr_acc  = avs_write & ~waitrequest_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= ~(bus_req & waitrequest_reg);
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    cur_word = 32'h0000_0000;
    unique case (avs_address & 6'h3C)
      `LACC_OFS_LOAD_CFG: begin
        cur_word[`LACC_FILT_EN_BIT]              = filt_en_reg;
        cur_word[`LACC_SENS_MSB:`LACC_SENS_LSB]  = sens_reg;
      end
      `LACC_OFS_SWITCH_MODE: cur_word[`LACC_STOP_STALL_BIT] = stop_en_reg;
      `LACC_OFS_COOL_CFG: begin
        cur_word[`LACC_LOWER_LSB +: 4] = lower_reg;
        cur_word[`LACC_SPAN_LSB +: 4]  = span_reg;
        cur_word[`LACC_INC_LSB +: 2]   = inc_reg;
        cur_word[`LACC_DEC_LSB +: 2]   = dec_reg;
        cur_word[`LACC_MINSEL_BIT]     = minsel_reg;
      end
      `LACC_OFS_CURRENT: begin
        cur_word[`LACC_RUN_LSB +: 5]  = run_reg;
        cur_word[`LACC_HOLD_LSB +: 5] = hold_reg;
      end
      `LACC_OFS_LOW_VEL:    cur_word[VEL_W-1:0] = low_vel_reg;
      `LACC_OFS_HIGH_VEL:   cur_word[VEL_W-1:0] = high_vel_reg;
      `LACC_OFS_STATUS: begin
        cur_word[`LACC_ST_LOAD_LSB +: 10] = load_status_reg;
        cur_word[`LACC_ST_SCALE_LSB +: 5] = scale_reg;      // readable scale [RL16]
        cur_word[`LACC_ST_ACTIVE_BIT]     = active_reg;
      end
      `LACC_OFS_IRQ_STATUS: cur_word[`LACC_IRQ_W-1:0] = irq_status_reg;
      `LACC_OFS_IRQ_MASK:   cur_word[`LACC_IRQ_W-1:0] = irq_mask_reg;
      default:              cur_word = 32'h0000_0000;
    endcase
  end

  assign wr_word = lacc_merge(cur_word, avs_writedata, avs_byteenable);

  // read word latched when waitrequest is about to drop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read & waitrequest_reg) begin
      readdata_reg <= cur_word;
    end
  end

  // --------------------
  // configuration writes
  // --------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_en_reg  <= 1'b0;
      sens_reg     <= `LACC_RST_SENS;  // neutral sensitivity [RL17]
      stop_en_reg  <= 1'b0;
      lower_reg    <= 4'h0;
      span_reg     <= 4'h0;
      inc_reg      <= 2'h0;
      dec_reg      <= 2'h0;
      minsel_reg   <= 1'b0;
      run_reg      <= `LACC_RST_RUN;
      hold_reg     <= `LACC_RST_HOLD;
      low_vel_reg  <= '0;
      high_vel_reg <= '0;
      irq_mask_reg <= '0;
    end else if (wr_acc) begin
      unique case (avs_address & 6'h3C)
        `LACC_OFS_LOAD_CFG: begin
          filt_en_reg <= wr_word[`LACC_FILT_EN_BIT];
          sens_reg    <= wr_word[`LACC_SENS_MSB:`LACC_SENS_LSB];  // signed setting [RL17]
        end
        `LACC_OFS_SWITCH_MODE: stop_en_reg <= wr_word[`LACC_STOP_STALL_BIT];
        `LACC_OFS_COOL_CFG: begin
          lower_reg  <= wr_word[`LACC_LOWER_LSB +: 4];
          span_reg   <= wr_word[`LACC_SPAN_LSB +: 4];
          inc_reg    <= wr_word[`LACC_INC_LSB +: 2];
          dec_reg    <= wr_word[`LACC_DEC_LSB +: 2];
          minsel_reg <= wr_word[`LACC_MINSEL_BIT];
        end
        `LACC_OFS_CURRENT: begin
          run_reg  <= wr_word[`LACC_RUN_LSB +: 5];
          hold_reg <= wr_word[`LACC_HOLD_LSB +: 5];
        end
        `LACC_OFS_LOW_VEL:  low_vel_reg  <= wr_word[VEL_W-1:0];
        `LACC_OFS_HIGH_VEL: high_vel_reg <= wr_word[VEL_W-1:0];
        `LACC_OFS_IRQ_MASK: irq_mask_reg <= wr_word[`LACC_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // --------------------
  // load reading path
  // --------------------
  logic       rd_valid;
  lacc_load_t rd_load;

  lacc_load_filter u_filter (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .filter_en (filt_en_reg),
    .in_valid  (full_step),   // one raw measurement per full step [RL1]
    .in_load   (meas_load),
    .out_valid (rd_valid),
    .out_load  (rd_load)
  );

  // last delivered reading kept for status
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_status_reg <= 10'h000;
    end else if (rd_valid) begin
      load_status_reg <= rd_load;
    end
  end

  // --------------------
  // regulation decision
  // --------------------
  logic [9:0]  lower_thr;
  logic [10:0] upper_thr;
  lacc_scale_t min_scale;
  lacc_scale_t idle_scale;
  lacc_scale_t step;
  logic [4:0]  dec_last;
  logic        win_ok;
  logic        active;
  lacc_adj_e   adj;
  logic [5:0]  up_sum;

  assign lower_thr = {lower_reg, 6'h00} >> 1;  // field times 32 [RL5]
  assign upper_thr = {2'h0, ({1'b0, lower_reg} + {1'b0, span_reg} + 5'h01), 4'h0} << 1;  // [RL7]
  assign min_scale = minsel_reg ? (run_reg >> 2) : (run_reg >> 1);  // half or quarter [RL11]
  assign step      = 5'h01 << inc_reg;  // 1, 2, 4, 8 [RL8]

  // last count value before a decrement: 32, 8, 2, 1 readings [RL9]
  always_comb begin
    unique case (dec_reg)
      2'h0: dec_last = 5'h1F;
      2'h1: dec_last = 5'h07;
      2'h2: dec_last = 5'h01;
      2'h3: dec_last = 5'h00;
    endcase
  end

  // velocity window, low bits dropped from both sides
  assign win_ok = (lacc_vel_hi(actual_velocity) >= lacc_vel_hi(low_vel_reg)) &&  // [RL13]
                  (lacc_vel_hi(actual_velocity) <= lacc_vel_hi(high_vel_reg));   // [RL14]
  assign active = win_ok && (lower_reg != 4'h0);  // zero field disables [RL5]
  assign idle_scale = standstill ? hold_reg : run_reg;  // normal current [RL13]

  always_comb begin
    adj = ADJ_KEEP;
    if (rd_valid) begin
      if (rd_load < lower_thr) begin
        adj = ADJ_UP;                           // [RL6]
      end else if ({1'b0, rd_load} >= upper_thr) begin
        adj = ADJ_COUNT;                        // [RL7]
      end else begin
        adj = ADJ_RESET;                        // dip below upper ends the run [RL10]
      end
    end
  end

  assign up_sum = {1'b0, scale_reg} + {1'b0, step};

  // next scale, clamped into the run/minimum band except a raise, which is only capped at run
  always_comb begin
    scale_next = lacc_clamp(scale_reg, min_scale, run_reg);  // [RL12]
    unique case (adj)
      ADJ_UP: begin
        scale_next = (up_sum > {1'b0, run_reg}) ? run_reg : up_sum[4:0];  // [RL6] [RL12]
      end
      ADJ_COUNT: begin
        if (hi_cnt_reg >= dec_last && scale_reg > min_scale) begin
          scale_next = lacc_clamp(scale_reg - 5'h01, min_scale, run_reg);  // [RL7] [RL12]
        end
      end
      ADJ_KEEP, ADJ_RESET: ;
    endcase
  end

  // --------------------
  // current scale and high-reading counter
  // --------------------
  // outside the window the scale follows the normal setting each cycle,
  // so re-entering the window starts from full current
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scale_reg  <= `LACC_RST_RUN;
      hi_cnt_reg <= 5'h00;
      active_reg <= 1'b0;
    end else begin
      active_reg <= active;
      if (!active) begin
        scale_reg  <= idle_scale;  // regulation off [RL13] [RL14]
        hi_cnt_reg <= 5'h00;
      end else begin
        scale_reg <= scale_next;
        unique case (adj)
          ADJ_COUNT: begin
            if (hi_cnt_reg >= dec_last) hi_cnt_reg <= 5'h00;  // restart after decrement [RL10]
            else hi_cnt_reg <= hi_cnt_reg + 5'h01;            // [RL9]
          end
          ADJ_UP, ADJ_RESET: hi_cnt_reg <= 5'h00;            // [RL10]
          ADJ_KEEP: ;
        endcase
      end
    end
  end

  // --------------------
  // events and interrupt
  // --------------------
  logic stall_evt;

  assign stall_evt = rd_valid && (rd_load == 10'h000);  // zero reading means stall [RL4]

  always_comb begin
    irq_set = '0;
    irq_set[`LACC_IRQ_STALL]   = stall_evt;
    irq_set[`LACC_IRQ_READING] = rd_valid;
    irq_set[`LACC_IRQ_RAISED]  = active && (scale_next > scale_reg);
    irq_set[`LACC_IRQ_LOWERED] = active && (scale_next < scale_reg);
    irq_clr = '0;
    if (wr_acc && ((avs_address & 6'h3C) == `LACC_OFS_IRQ_STATUS)) begin
      irq_clr = wr_word[`LACC_IRQ_W-1:0];
    end
  end

  // set wins over a simultaneous write-one clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
      irq_reg        <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      irq_reg        <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

  // stop request held while a stall is flagged; software clears the flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= stop_en_reg &&
                  (stall_evt || (irq_status_reg[`LACC_IRQ_STALL] && !irq_clr[`LACC_IRQ_STALL]));  // [RL4]
    end
  end

  // --------------------
  // outputs
  // --------------------
  // stall detection is not gated by velocity; software owns that [RL18]
  assign avs_readdata         = readdata_reg;
  assign avs_waitrequest      = waitrequest_reg;
  assign stall_sensitivity    = sens_reg;
  assign ramp_stop            = stop_reg;
  assign actual_current_scale = scale_reg;
  assign irq                  = irq_reg;
endmodule : lacc_top

// ### tb/lacc_top_asserts.sv
// checker for bus, stall stop, irq and scale timing
`timescale 1ns/1ps
module lacc_top_asserts #(
  parameter int VEL_W = 23
) (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  // avalon-mm slave
  input wire logic [5:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  // load path and ramp
  input wire logic                 full_step,
  input wire lacc_pkg::lacc_sens_t stall_sensitivity,
  input wire logic [VEL_W-1:0]     actual_velocity,
  input wire logic                 standstill,
  input wire logic                 ramp_stop,
  // coil drive and interrupt
  input wire lacc_pkg::lacc_scale_t actual_current_scale,
  input wire logic                 irq
);
  import lacc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] quiet_reg;
  // cycles since last stimulus; saturates so it never wraps
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) quiet_reg <= 3'h0;
    else if (full_step || avs_write || $changed(actual_velocity) || $changed(standstill))
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
  end
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  sequence req_waiting;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  wait_one_a: assert property (req_waiting |=> one_answer)
    else $error("wait state not one cycle");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("answer without request");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("readdata moved unread");
  // ----------------------------------------
  // outputs follow their causes
  // ----------------------------------------
  sens_write_a: assert property ($changed(stall_sensitivity) |->
    $past(avs_write && !avs_waitrequest && avs_address[5:2] == 4'h0))
    else $error("sensitivity moved without a write");
  stop_rise_a: assert property ($rose(ramp_stop) |-> quiet_reg <= 3'h4)
    else $error("stop rose uncaused");
  stop_fall_a: assert property ($fell(ramp_stop) |->
    $past(avs_write && !avs_waitrequest))
    else $error("stop fell unwritten");
  irq_rise_a: assert property ($rose(irq) |-> quiet_reg <= 3'h4)
    else $error("irq rose without a cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(avs_write, 2) || $past(avs_write, 3))
    else $error("irq fell without a write");
  scale_move_a: assert property ($changed(actual_current_scale) |-> quiet_reg <= 3'h4)
    else $error("scale moved uncaused");
endmodule : lacc_top_asserts

bind lacc_top lacc_top_asserts #(.VEL_W(VEL_W)) lacc_top_asserts_i (.ref_clk, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .full_step,
  .stall_sensitivity, .actual_velocity, .standstill, .ramp_stop, .actual_current_scale, .irq);

// ### tb/lacc_motor_model.sv
// motor-side model: one load reading per full step
`timescale 1ns/1ps
module lacc_motor_model (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // step request from the bench
  input  wire logic                 step_req,
  input  wire lacc_pkg::lacc_load_t load_val,
  // load measurement toward the block
  output logic                      full_step,
  output lacc_pkg::lacc_load_t      meas_load
);
  import lacc_pkg::*;
  // one pulse per step; reading scrambled between steps
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      full_step <= 1'b0;
      meas_load <= 10'h000;
    end else begin
      full_step <= step_req;
      meas_load <= step_req ? load_val : ~meas_load;
    end
  end
endmodule : lacc_motor_model

// ### tb/load_adaptive_current_control_tb.sv
// self-checking bench for the load-adaptive current block
`timescale 1ns/1ps
`include "lacc_defs.svh"
module load_adaptive_current_control_tb;
  import lacc_pkg::*;
  typedef struct {
    logic [15:0] cfg;
    logic [4:0]  run;
    logic [22:0] vel;
    lacc_load_t  load;
    lacc_scale_t exp;
  } lacc_row_s;
  logic        ref_clk, rst_n, avs_read, avs_write, full_step, standstill, ramp_stop, irq;
  logic        step_req, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [22:0] actual_velocity;
  lacc_load_t  meas_load, load_val;
  lacc_sens_t  stall_sensitivity;
  lacc_scale_t actual_current_scale;
  int          fail_count, total_checks;
  // cfg: lower, span, inc code, dec code, min select; vel window 0x100..0x1000
  lacc_row_s rows [20] = '{
    '{16'h0C12, 5'h10, 23'h200, 10'h0C8, 5'h0F}, '{16'h0C12, 5'h10, 23'h200, 10'h080, 5'h0E},
    '{16'h0C12, 5'h10, 23'h200, 10'h07F, 5'h0E}, '{16'h0C12, 5'h10, 23'h200, 10'h040, 5'h0E},
    '{16'h0C12, 5'h10, 23'h200, 10'h03F, 5'h0F}, '{16'h0F12, 5'h10, 23'h200, 10'h00A, 5'h10},
    '{16'h0912, 5'h10, 23'h200, 10'h0C8, 5'h10}, '{16'h0912, 5'h10, 23'h200, 10'h0C8, 5'h0F},
    '{16'h0812, 5'h10, 23'h200, 10'h00A, 5'h10}, '{16'h0A12, 5'h1F, 23'h200, 10'h032, 5'h14},
    '{16'h0C12, 5'h04, 23'h200, 10'h0C8, 5'h03}, '{16'h0C12, 5'h04, 23'h200, 10'h0C8, 5'h02},
    '{16'h0C12, 5'h04, 23'h200, 10'h0C8, 5'h02}, '{16'h1C12, 5'h04, 23'h200, 10'h0C8, 5'h01},
    '{16'h1C12, 5'h04, 23'h200, 10'h0C8, 5'h01}, '{16'h0C10, 5'h04, 23'h200, 10'h0C8, 5'h04},
    '{16'h0C12, 5'h10, 23'h0FF, 10'h0C8, 5'h10}, '{16'h0C12, 5'h10, 23'h10FF, 10'h0C8, 5'h0F},
    '{16'h0C12, 5'h10, 23'h1100, 10'h0C8, 5'h10}, '{16'h0C12, 5'h10, 23'h100, 10'h0C8, 5'h0F}};

  lacc_top lacc_top_i (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .full_step, .meas_load,
    .stall_sensitivity, .actual_velocity, .standstill, .ramp_stop, .actual_current_scale, .irq);
  lacc_motor_model lacc_motor_model_i (.ref_clk, .rst_n, .step_req, .load_val, .full_step,
    .meas_load);

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one avalon cycle held until waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      finish_test();
    end
  endtask : bus

  // one full step plus settle time
  task automatic step(input lacc_load_t ld);
    @(posedge ref_clk);
    step_req <= 1'b1;
    load_val <= ld;
    @(posedge ref_clk);
    step_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : step

  task automatic reset_check();
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    check("scale", actual_current_scale, 5'h1F);
    check("sens", {stall_sensitivity}, 7'h00);
    check("stop", ramp_stop, 1'b0);
    check("irq", irq, 1'b0);
    bus(1'b0, `LACC_OFS_CURRENT, 32'h0, q);
    check("current", q, 32'h0000081F);
    bus(1'b0, 6'h3C, 32'h0, q);
    check("unmapped", q, 32'h0);
  endtask : reset_check

  initial begin
    {rst_n, avs_read, avs_write, step_req, standstill} = 5'h00;
    {avs_address, avs_writedata, actual_velocity, load_val} = '0;
    fail_count = 0;
    total_checks = 0;
    reset_check();
    bus(1'b1, `LACC_OFS_LOW_VEL, 32'h100, q);
    bus(1'b1, `LACC_OFS_HIGH_VEL, 32'h1000, q);
    // one reading per row
    foreach (rows[i]) begin
      actual_velocity <= rows[i].vel;
      bus(1'b1, `LACC_OFS_COOL_CFG, {16'h0, rows[i].cfg}, q);
      bus(1'b1, `LACC_OFS_CURRENT, {19'h0, 5'h08, 3'h0, rows[i].run}, q);
      step(rows[i].load);
      check("scale", actual_current_scale, rows[i].exp);
      bus(1'b0, `LACC_OFS_STATUS, 32'h0, q);
      check("status", {q[20:16], q[9:0]}, {rows[i].exp, rows[i].load});
    end
    // eight high readings per decrement, count restarted by a dip
    bus(1'b1, `LACC_OFS_COOL_CFG, 32'h0412, q);
    repeat (4) step(10'h0C8);
    step(10'h064);
    repeat (7) step(10'h0C8);
    check("scale", actual_current_scale, 5'h0F);
    step(10'h0C8);
    check("scale", actual_current_scale, 5'h0E);
    // standstill: hold current
    actual_velocity <= 23'h0;
    standstill <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("scale", actual_current_scale, 5'h08);
    standstill <= 1'b0;
    // filtered: mean of four steps
    bus(1'b1, `LACC_OFS_LOAD_CFG, 32'h007B0001, q);
    step(10'h064);
    step(10'h0C8);
    step(10'h12C);
    bus(1'b0, `LACC_OFS_STATUS, 32'h0, q);
    check("reading", q[9:0], 10'h0C8);
    step(10'h194);
    bus(1'b0, `LACC_OFS_STATUS, 32'h0, q);
    check("reading", q[9:0], 10'h0FB);
    check("sens", {stall_sensitivity}, 7'h7B);
    bus(1'b1, `LACC_OFS_LOAD_CFG, 32'h0, q);
    // stall stop enabled only for this scenario
    bus(1'b1, `LACC_OFS_IRQ_MASK, 32'h0, q);
    bus(1'b1, `LACC_OFS_SWITCH_MODE, 32'h1, q);
    step(10'h000);
    check("stop", ramp_stop, 1'b1);
    check("irq", irq, 1'b0);
    bus(1'b0, `LACC_OFS_IRQ_STATUS, 32'h0, q);
    check("flags", q[0], 1'b1);
    bus(1'b1, `LACC_OFS_IRQ_MASK, 32'hF, q);
    repeat (3) @(posedge ref_clk);
    check("irq", irq, 1'b1);
    bus(1'b1, `LACC_OFS_IRQ_STATUS, 32'hF, q);
    repeat (3) @(posedge ref_clk);
    check("irq", irq, 1'b0);
    check("stop", ramp_stop, 1'b0);
    // second reset in mid-run
    reset_check();
    finish_test();
  end
endmodule : load_adaptive_current_control_tb
